/* File: hdl/iped_pkg.sv */
// Purpose: Constants for the input port edge event block
// Assumes: One 250 MHz clock, AHB-Lite register access, word transfers only
// Notes:   Two groups of four input pins, one event flag per group
//
// Overview of operation
// - With falling polarity chosen, a high-to-low pin change sets its group event flag.
// - With falling polarity chosen, a low pin level is the active condition.
// - With rising polarity chosen, a high pin level is active and a low-to-high change sets the flag.
// - Clearing then setting a mask bit while its pin sits active sets the group flag again.
// - With the mask set, changing polarity so the present level turns active sets the flag.
// - A group flag is never set by a pin whose mask bit is clear.
// - Reading the flag register returns the flags and clears them.
package iped_pkg;
  // Bus geometry
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam int          GRP_W       = 4;
  // Register byte offsets
  localparam logic [7:0]  OFS_PIN     = 8'h00;
  localparam logic [7:0]  OFS_MASK    = 8'h04;
  localparam logic [7:0]  OFS_POL     = 8'h08;
  localparam logic [7:0]  OFS_FLAG    = 8'h0C;
  // Field positions inside PIN, MASK and POL
  localparam int          G0_LSB      = 0;
  localparam int          G1_LSB      = 4;
  // Field positions inside FLAG
  localparam int          FLAG_G0_BIT = 0;
  localparam int          FLAG_G1_BIT = 1;
  // Reset values
  localparam logic [7:0]  MASK_RST    = 8'h00;
  localparam logic [7:0]  POL_RST     = 8'h00;
  localparam logic [1:0]  FLAG_RST    = 2'h0;
  // Polarity encoding: 1 selects falling edge, active low
  localparam logic        POL_FALL    = 1'h1;
  localparam logic        POL_RISE    = 1'h0;
  // AHB transfer types and response
  localparam logic [1:0]  HTRANS_IDLE = 2'h0;
  localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
  localparam logic        HRESP_OKAY  = 1'h0;
endpackage

/* File: hdl/iped_grp.sv */
// Purpose: Active-condition rise detector for one group of input pins
// Assumes: Pins already synchronous to CLK
// Notes:   One pulse per group whenever any pin turns newly active
`timescale 1ns/10ps
module iped_grp #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Pins and controls
  input  wire logic [W-1:0] pin,
  input  wire logic [W-1:0] mask,
  input  wire logic [W-1:0] pol,
  // Results
  output logic      [W-1:0] act_raw,
  output logic      [W-1:0] act_ff,
  output logic              set_pulse
);
  // Masked, polarity-adjusted level; a masked pin is never active
  assign act_raw   = mask & (pin ^ pol);
  // Rise of the level covers edges, mask re-enable and polarity flips alike
  assign set_pulse = |(act_raw & ~act_ff);

  // Previous level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      act_ff <= '0;
    end else begin
      act_ff <= act_raw;
    end
  end
endmodule

/* File: hdl/iped_ahb.sv */
// Purpose: AHB-Lite slave front end, zero wait states
// Assumes: Single word transfers, one slave on the bus
// Notes:   Reads act in the address phase, writes in the data phase
`timescale 1ns/10ps
module iped_ahb (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  // Address phase
  input  wire logic                         hsel,
  input  wire logic [1:0]                   htrans,
  input  wire logic [iped_pkg::ADDR_W-1:0]  haddr,
  input  wire logic                         hwrite,
  input  wire logic                         hready,
  // Decoded strobes
  output logic                              rd_en,
  output logic      [iped_pkg::ADDR_W-1:0]  rd_addr,
  output logic                              wr_en,
  output logic      [iped_pkg::ADDR_W-1:0]  wr_addr
);
  logic                        valid;
  logic                        wr_pend_ff;
  logic [iped_pkg::ADDR_W-1:0] wr_addr_ff;

  // Transfer accepted this edge; bit 1 set means NONSEQ or SEQ
  assign valid   = hsel & htrans[1] & hready;
  assign rd_en   = valid & ~hwrite;
  assign rd_addr = haddr;
  assign wr_en   = wr_pend_ff;
  assign wr_addr = wr_addr_ff;

  // Hold the write address until its data phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_ff <= 1'h0;
      wr_addr_ff <= '0;
    end else begin
      wr_pend_ff <= valid & hwrite;
      wr_addr_ff <= haddr;
    end
  end
endmodule

/* File: hdl/iped_top.sv */
// Purpose: Input port edge event block with AHB-Lite register access
// Assumes: Pins synchronous to CLK; software keeps its own sequencing duties
// Notes:   Flags are levels; this block raises no interrupt of its own
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module iped_top (
  // Clock and reset
  input  wire logic                         CLK,
  input  wire logic                         RST_B,
  // AHB-Lite slave
  input  wire logic                         HSEL,
  input  wire logic [1:0]                   HTRANS,
  input  wire logic [iped_pkg::ADDR_W-1:0]  HADDR,
  input  wire logic                         HWRITE,
  input  wire logic [2:0]                   HSIZE,
  input  wire logic [iped_pkg::DATA_W-1:0]  HWDATA,
  input  wire logic                         HREADY,
  output logic      [iped_pkg::DATA_W-1:0]  HRDATA,
  output logic                              HREADYOUT,
  output logic                              HRESP,
  // Input pins
  input  wire logic [iped_pkg::GRP_W-1:0]   KIN_GROUP0,
  input  wire logic [iped_pkg::GRP_W-1:0]   KIN_GROUP1,
  // Event flags
  output logic                              INPUT_GROUP0_EVENT_FLAG,
  output logic                              INPUT_GROUP1_EVENT_FLAG
);
  localparam int GW = iped_pkg::GRP_W;

  // Bus strobes
  logic                        rd_en;
  logic [iped_pkg::ADDR_W-1:0] rd_addr;
  logic                        wr_en;
  logic [iped_pkg::ADDR_W-1:0] wr_addr;

  // Registers
  logic [2*GW-1:0]             mask_ff;
  logic [2*GW-1:0]             pol_ff;
  logic [1:0]                  flag_ff;
  logic [iped_pkg::DATA_W-1:0] rdata_ff;
  logic [2*GW-1:0]             nxt_mask;
  logic [2*GW-1:0]             nxt_pol;
  logic [1:0]                  nxt_flag;
  logic [iped_pkg::DATA_W-1:0] nxt_rdata;

  // Group results
  logic [GW-1:0]               act_raw0;
  logic [GW-1:0]               act_raw1;
  logic [GW-1:0]               act0_ff;
  logic [GW-1:0]               act1_ff;
  logic                        set0;
  logic                        set1;

  // Decodes
  logic                        wr_mask;
  logic                        wr_pol;
  logic                        rd_pin;
  logic                        rd_mask;
  logic                        rd_pol;
  logic                        rd_flag;
  logic [1:0]                  set_vec;
  logic [2*GW-1:0]             pins;

  // Bus front end
  iped_ahb u_ahb (
    .clk     (CLK),
    .rst_b   (RST_B),
    .hsel    (HSEL),
    .htrans  (HTRANS),
    .haddr   (HADDR),
    .hwrite  (HWRITE),
    .hready  (HREADY),
    .rd_en   (rd_en),
    .rd_addr (rd_addr),
    .wr_en   (wr_en),
    .wr_addr (wr_addr)
  );

  // Pin group 0 detector
  iped_grp #(.W(GW)) u_grp0 (
    .clk       (CLK),
    .rst_b     (RST_B),
    .pin       (KIN_GROUP0),
    .mask      (mask_ff[iped_pkg::G0_LSB +: GW]),
    .pol       (pol_ff[iped_pkg::G0_LSB +: GW]),
    .act_raw   (act_raw0),
    .act_ff    (act0_ff),
    .set_pulse (set0)
  );

  // Pin group 1 detector
  iped_grp #(.W(GW)) u_grp1 (
    .clk       (CLK),
    .rst_b     (RST_B),
    .pin       (KIN_GROUP1),
    .mask      (mask_ff[iped_pkg::G1_LSB +: GW]),
    .pol       (pol_ff[iped_pkg::G1_LSB +: GW]),
    .act_raw   (act_raw1),
    .act_ff    (act1_ff),
    .set_pulse (set1)
  );

  // Register decodes; HSIZE is not checked, only word access is supported
  assign wr_mask = wr_en & (wr_addr == iped_pkg::OFS_MASK);
  assign wr_pol  = wr_en & (wr_addr == iped_pkg::OFS_POL);
  assign rd_pin  = rd_en & (rd_addr == iped_pkg::OFS_PIN);
  assign rd_mask = rd_en & (rd_addr == iped_pkg::OFS_MASK);
  assign rd_pol  = rd_en & (rd_addr == iped_pkg::OFS_POL);
  assign rd_flag = rd_en & (rd_addr == iped_pkg::OFS_FLAG);
  assign pins    = {KIN_GROUP1, KIN_GROUP0};

  // Control register next values
  assign nxt_mask = wr_mask ? HWDATA[2*GW-1:0] : mask_ff;
  assign nxt_pol  = wr_pol ? HWDATA[2*GW-1:0] : pol_ff;

  // Flags: set beats the read-clear so no event is lost
  assign set_vec  = {set1, set0};
  assign nxt_flag = set_vec | (flag_ff & {2{~rd_flag}});

  // Read mux; unmapped offsets read zero
  assign nxt_rdata = rd_pin  ? {{(iped_pkg::DATA_W-2*GW){1'b0}}, pins} :
                     rd_mask ? {{(iped_pkg::DATA_W-2*GW){1'b0}}, mask_ff} :
                     rd_pol  ? {{(iped_pkg::DATA_W-2*GW){1'b0}}, pol_ff} :
                     rd_flag ? {{(iped_pkg::DATA_W-2){1'b0}}, flag_ff} :
                               '0;

  // Mask and polarity registers
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      mask_ff <= iped_pkg::MASK_RST;
      pol_ff  <= iped_pkg::POL_RST;
    end else begin
      mask_ff <= nxt_mask;
      pol_ff  <= nxt_pol;
    end
  end

  // Event flags, sticky until read
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      flag_ff <= iped_pkg::FLAG_RST;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  // Read data captured at the address phase edge
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Outputs
  assign HRDATA                  = rdata_ff;
  assign HREADYOUT               = 1'h1; // Never stalls
  assign HRESP                   = iped_pkg::HRESP_OKAY;
  assign INPUT_GROUP0_EVENT_FLAG = flag_ff[iped_pkg::FLAG_G0_BIT];
  assign INPUT_GROUP1_EVENT_FLAG = flag_ff[iped_pkg::FLAG_G1_BIT];

  // Checks on pin 0 of group 0, bar a_set_beats_clear on group 1 and a_read_returns on both flags; the other pins share the same logic
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  // Helper terms for pin 0 of group 0
  logic m0;
  logic p0;
  logic k0;
  assign m0 = mask_ff[iped_pkg::G0_LSB];
  assign p0 = pol_ff[iped_pkg::G0_LSB];
  assign k0 = KIN_GROUP0[0];

  a_fall_sets_flag: assert property (
    (m0 && p0 == iped_pkg::POL_FALL && !k0 &&
     $past(m0 && p0 == iped_pkg::POL_FALL && k0)) |=> INPUT_GROUP0_EVENT_FLAG)
    else $error("Falling edge did not set group 0 flag");

  a_low_is_active: assert property (
    (m0 && p0 == iped_pkg::POL_FALL && !k0) |=> act0_ff[0])
    else $error("Low pin not active under falling polarity");

  a_rise_sets_flag: assert property (
    (m0 && p0 == iped_pkg::POL_RISE && k0 &&
     $past(m0 && p0 == iped_pkg::POL_RISE && !k0)) |=> INPUT_GROUP0_EVENT_FLAG)
    else $error("Rising edge did not set group 0 flag");

  a_mask_reenable: assert property (
    ($rose(m0) && (k0 ^ p0)) |=> INPUT_GROUP0_EVENT_FLAG)
    else $error("Mask re-enable on active pin did not set flag");

  a_pol_flip_sets: assert property (
    (m0 && $past(m0) && $changed(p0) && $stable(k0) && (k0 ^ p0)) |=> INPUT_GROUP0_EVENT_FLAG)
    else $error("Polarity change to active did not set flag");

  a_masked_no_flag: assert property (
    (mask_ff[iped_pkg::G0_LSB +: GW] == '0 && !INPUT_GROUP0_EVENT_FLAG)
      |=> !INPUT_GROUP0_EVENT_FLAG [*1])
    else $error("Flag set while group 0 fully masked");

  a_read_clears: assert property (
    (rd_flag && !set0) |=> !INPUT_GROUP0_EVENT_FLAG)
    else $error("Flag read did not clear group 0 flag");

  a_read_returns: assert property (
    rd_flag |=> HRDATA[1:0] == $past(flag_ff))
    else $error("Flag read returned wrong value");

  a_flag_has_cause: assert property (
    $rose(INPUT_GROUP0_EVENT_FLAG) |-> $past(|(act_raw0 & ~act0_ff)))
    else $error("Group 0 flag rose without an active rise");

  a_set_beats_clear: assert property (
    (rd_flag && set1) |=> INPUT_GROUP1_EVENT_FLAG)
    else $error("Read clear lost a same-cycle event");

  // Checks on pin 0 of group 1, whose flag bit sits apart from group 0, plus a_high_is_active and a_flag0_holds on group 0
  logic m1;
  logic p1;
  logic k1;
  assign m1 = mask_ff[iped_pkg::G1_LSB];
  assign p1 = pol_ff[iped_pkg::G1_LSB];
  assign k1 = KIN_GROUP1[0];

  a_fall_sets_g1: assert property (
    (m1 && p1 == iped_pkg::POL_FALL && !k1 &&
     $past(m1 && p1 == iped_pkg::POL_FALL && k1)) |=> INPUT_GROUP1_EVENT_FLAG)
    else $error("Falling edge did not set group 1 flag");

  a_low_active_g1: assert property (
    (m1 && p1 == iped_pkg::POL_FALL && !k1) |=> act1_ff[0])
    else $error("Low pin not active under falling polarity in group 1");

  a_high_is_active: assert property (
    (m0 && p0 == iped_pkg::POL_RISE && k0) |=> act0_ff[0])
    else $error("High pin not active under rising polarity");

  a_rise_sets_g1: assert property (
    (m1 && p1 == iped_pkg::POL_RISE && k1 &&
     $past(m1 && p1 == iped_pkg::POL_RISE && !k1)) |=> INPUT_GROUP1_EVENT_FLAG)
    else $error("Rising edge did not set group 1 flag");

  a_remask_sets_g1: assert property (
    ($rose(m1) && (k1 ^ p1)) |=> INPUT_GROUP1_EVENT_FLAG)
    else $error("Mask re-enable on active pin did not set group 1 flag");

  a_pol_flip_g1: assert property (
    (m1 && $past(m1) && $changed(p1) && $stable(k1) && (k1 ^ p1)) |=> INPUT_GROUP1_EVENT_FLAG)
    else $error("Polarity change to active did not set group 1 flag");

  a_masked_quiet_g1: assert property (
    (mask_ff[iped_pkg::G1_LSB +: GW] == '0 && !INPUT_GROUP1_EVENT_FLAG)
      |=> !INPUT_GROUP1_EVENT_FLAG)
    else $error("Flag set while group 1 fully masked");

  a_read_clears_g1: assert property (
    (rd_flag && !set1) |=> !INPUT_GROUP1_EVENT_FLAG)
    else $error("Flag read did not clear group 1 flag");

  a_cause_g1: assert property (
    $rose(INPUT_GROUP1_EVENT_FLAG) |-> $past(|(act_raw1 & ~act1_ff)))
    else $error("Group 1 flag rose without an active rise");

  a_flag0_holds: assert property (
    (INPUT_GROUP0_EVENT_FLAG && !rd_flag) |=> INPUT_GROUP0_EVENT_FLAG)
    else $error("Group 0 flag dropped without a read");

  a_flag1_holds: assert property (
    (INPUT_GROUP1_EVENT_FLAG && !rd_flag) |=> INPUT_GROUP1_EVENT_FLAG)
    else $error("Group 1 flag dropped without a read");

  // Register bus effects; a lost or stray write would bend every flag check above
  a_mask_write_lands: assert property (
    wr_mask |=> mask_ff == $past(HWDATA[2*GW-1:0]))
    else $error("Mask write did not land");

  a_mask_holds: assert property (
    !wr_mask |=> $stable(mask_ff))
    else $error("Mask changed without a write");

  a_pol_write_lands: assert property (
    wr_pol |=> pol_ff == $past(HWDATA[2*GW-1:0]))
    else $error("Polarity write did not land");

  a_pol_holds: assert property (
    !wr_pol |=> $stable(pol_ff))
    else $error("Polarity changed without a write");

  a_pin_read_value: assert property (
    rd_pin |=> HRDATA[2*GW-1:0] == $past(pins))
    else $error("Pin read returned wrong value");

  a_unmapped_zero: assert property (
    (rd_en && !rd_pin && !rd_mask && !rd_pol && !rd_flag) |=> HRDATA == '0)
    else $error("Unmapped read returned nonzero data");

  // Main scenarios
  c_fall_event: cover property (m0 && p0 == iped_pkg::POL_FALL && $fell(k0) ##1 INPUT_GROUP0_EVENT_FLAG);
  c_mask_reenable: cover property ($fell(m0) ##[1:4] $rose(m0) ##1 INPUT_GROUP0_EVENT_FLAG);
  c_read_clear: cover property (INPUT_GROUP0_EVENT_FLAG && rd_flag ##1 !INPUT_GROUP0_EVENT_FLAG);
  c_set_and_clear: cover property (rd_flag && set0);
  c_pol_flip: cover property (m0 && $changed(p0) ##1 INPUT_GROUP0_EVENT_FLAG);
endmodule

/* File: verif/iped_keys.sv */
// Purpose: Key switches with pull-ups driving the two pin groups
// Assumes: Commanded levels change just after a clock edge
// Notes:   Slow mode adds one cycle of settling, like a weak pull-up
`timescale 1ns/10ps
module iped_keys (
  // Clock
  input  wire logic       clk,
  // Commands
  input  wire logic       slow,
  input  wire logic [3:0] want0,
  input  wire logic [3:0] want1,
  // Pins
  output logic      [3:0] kin0,
  output logic      [3:0] kin1
);
  logic [7:0] stage_ff;

  // Pins follow the command after one or two edges
  always_ff @(posedge clk) begin
    stage_ff <= {want1, want0};
    kin0     <= slow ? stage_ff[3:0] : want0;
    kin1     <= slow ? stage_ff[7:4] : want1;
  end
endmodule

/* File: verif/iped_top_test.sv */
// Purpose: Self-checking bench for the input port edge event block
// Assumes: Zero-wait AHB-Lite slave, pins idle high through pull-ups
// Notes:   Software ordering duties are kept by the scenarios themselves
`timescale 1ns/10ps
module iped_top_test;
  logic        CLK, RST_B, HSEL, HWRITE, SLOW;
  logic [1:0]  HTRANS;
  logic [7:0]  HADDR;
  logic [31:0] HWDATA, HRDATA, rd;
  logic        HREADYOUT, HRESP, FLAG0, FLAG1;
  logic [3:0]  WANT0, WANT1, KIN0, KIN1;
  int          mismatches, samples_checked, cycles;

  iped_keys iped_keys_i (.clk(CLK), .slow(SLOW), .want0(WANT0), .want1(WANT1), .kin0(KIN0), .kin1(KIN1));
  iped_top iped_top_i (.CLK(CLK), .RST_B(RST_B), .HSEL(HSEL), .HTRANS(HTRANS), .HADDR(HADDR),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .KIN_GROUP0(KIN0), .KIN_GROUP1(KIN1),
    .INPUT_GROUP0_EVENT_FLAG(FLAG0), .INPUT_GROUP1_EVENT_FLAG(FLAG1));

  // Clock and a hang limit well above the run length
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One single transfer; waits on ready in both phases
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge CLK);
    HSEL   <= 1'b1;
    HTRANS <= iped_pkg::HTRANS_NSEQ;
    HADDR  <= a;
    HWRITE <= wr;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL   <= 1'b0;
    HTRANS <= iped_pkg::HTRANS_IDLE;
    HWDATA <= wd;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask

  // Pins move, then enough edges for model, sampling and flag
  task automatic pins(input logic [3:0] g0, input logic [3:0] g1);
    @(posedge CLK);
    WANT0 <= g0;
    WANT1 <= g1;
    repeat (6) @(posedge CLK);
  endtask

  task automatic flags(input logic [1:0] exp);
    repeat (3) @(posedge CLK);
    chk({30'h0, FLAG1, FLAG0}, {30'h0, exp});
  endtask

  task automatic t_reset();
    chk({31'h0, HRESP}, 32'h0);
    ahb(1'b0, iped_pkg::OFS_MASK, 32'h0); chk(rd, 32'h0);
    ahb(1'b0, iped_pkg::OFS_POL, 32'h0); chk(rd, 32'h0);
    ahb(1'b0, iped_pkg::OFS_FLAG, 32'h0); chk(rd, 32'h0);
    ahb(1'b1, 8'h10, 32'hFF); ahb(1'b0, 8'h10, 32'h0); chk(rd, 32'h0);
    ahb(1'b0, iped_pkg::OFS_PIN, 32'h0); chk(rd, 32'hFF);
  endtask

  task automatic t_rise();
    pins(4'hE, 4'hF);
    ahb(1'b1, iped_pkg::OFS_MASK, 32'h01);
    flags(2'h0);
    pins(4'hF, 4'hF);
    flags(2'h1);
    ahb(1'b0, iped_pkg::OFS_FLAG, 32'h0); chk(rd, 32'h1);
    flags(2'h0);
    ahb(1'b0, iped_pkg::OFS_FLAG, 32'h0); chk(rd, 32'h0);
  endtask

  task automatic t_fall();
    SLOW <= 1'b1;
    ahb(1'b1, iped_pkg::OFS_MASK, 32'h00);
    ahb(1'b1, iped_pkg::OFS_POL, 32'h10);
    ahb(1'b1, iped_pkg::OFS_MASK, 32'h10);
    flags(2'h0);
    pins(4'hF, 4'hE);
    flags(2'h2);
    ahb(1'b0, iped_pkg::OFS_FLAG, 32'h0); chk(rd, 32'h2);
    SLOW <= 1'b0;
  endtask

  task automatic t_masked();
    ahb(1'b1, iped_pkg::OFS_MASK, 32'h00);
    pins(4'h0, 4'hF);
    pins(4'hF, 4'h0);
    flags(2'h0);
    ahb(1'b0, iped_pkg::OFS_FLAG, 32'h0); chk(rd, 32'h0);
  endtask

  task automatic t_remask();
    pins(4'hF, 4'hE);
    ahb(1'b1, iped_pkg::OFS_MASK, 32'h10);
    flags(2'h2);
    ahb(1'b0, iped_pkg::OFS_FLAG, 32'h0); chk(rd, 32'h2);
  endtask

  task automatic t_pol();
    ahb(1'b1, iped_pkg::OFS_MASK, 32'h00);
    ahb(1'b1, iped_pkg::OFS_POL, 32'h00);
    pins(4'hE, 4'hF);
    ahb(1'b1, iped_pkg::OFS_MASK, 32'h01);
    flags(2'h0);
    ahb(1'b1, iped_pkg::OFS_POL, 32'h01);
    flags(2'h1);
    ahb(1'b0, iped_pkg::OFS_FLAG, 32'h0); chk(rd, 32'h1);
  endtask

  // Main sequence
  initial begin
    RST_B = 1'b0; HSEL = 1'b0; HWRITE = 1'b0; SLOW = 1'b0;
    HTRANS = iped_pkg::HTRANS_IDLE; HADDR = 8'h00; HWDATA = 32'h0;
    WANT0 = 4'hF; WANT1 = 4'hF;
    mismatches = 0; samples_checked = 0; cycles = 0;
    repeat (8) @(posedge CLK);
    RST_B <= 1'b1;
    t_reset();
    t_rise();
    t_fall();
    t_masked();
    t_remask();
    t_pol();
    end_of_test();
  end
endmodule
